// ===== logic/ddshp_params.svh
// Purpose: constants shared by both ends of the oscillator write port
// Assumes: one core clock at 250 MHz on both ends
// Notes:   byte selects, reset values and host strobe pacing
`ifndef DDSHP_PARAMS_SVH
`define DDSHP_PARAMS_SVH

`define DDSHP_NUM_REGS      12
`define DDSHP_SEL_W         4
`define DDSHP_DATA_W        8
`define DDSHP_WORD_W        48
`define DDSHP_SAMPLE_W      16
`define DDSHP_OF_BASE       6
`define DDSHP_CF_MSB_IDX    5
`define DDSHP_CF_MSB_RESET  8'h40
`define DDSHP_BYTE_RESET    8'h00
`define DDSHP_CLK_NS        4
`define DDSHP_PHASE_NS      12
`define DDSHP_PHASE_CYC     ((`DDSHP_PHASE_NS + `DDSHP_CLK_NS - 1) / `DDSHP_CLK_NS)
`define DDSHP_CNT_W         4

`endif

// ===== logic/ddshp_pkg.sv
// Purpose: types for the oscillator write port
// Assumes: ddshp_params.svh holds the numbers
// Notes:   none
`include "ddshp_params.svh"

package ddshp_pkg;
  typedef logic [`DDSHP_WORD_W-1:0]   ddshp_word_t;
  typedef logic [`DDSHP_DATA_W-1:0]   ddshp_byte_t;
  typedef logic [`DDSHP_SEL_W-1:0]    ddshp_sel_t;
  typedef logic [`DDSHP_SAMPLE_W-1:0] ddshp_sample_t;
  typedef enum logic [1:0] {
    DDSHP_H_IDLE,
    DDSHP_H_SETUP,
    DDSHP_H_HIGH,
    DDSHP_H_HOLD
  } ddshp_hstate_t;
endpackage : ddshp_pkg

// ===== logic/ddshp_if.sv
// Purpose: pins between host and oscillator
// Assumes: all pins driven by the host end
// Notes:   plain one-way wires, no clocking block
`timescale 1ns/10ps
`default_nettype none

interface ddshp_if;
  import ddshp_pkg::*;
  logic          wr_strobe;
  logic          wr_sel_n;
  ddshp_sel_t    reg_sel;
  ddshp_byte_t   data;
  logic          commit_n;
  logic          reset_n;
  logic          offset_gate;
  logic [1:0]    phase_quadrant_sel;

  modport dev (
    input wr_strobe, wr_sel_n, reg_sel, data, commit_n, reset_n,
          offset_gate, phase_quadrant_sel
  );
  modport hst (
    output wr_strobe, wr_sel_n, reg_sel, data, commit_n, reset_n,
           offset_gate, phase_quadrant_sel
  );
endinterface : ddshp_if

`default_nettype wire

// ===== logic/ddshp_device.sv
// Purpose: oscillator end: staged and active frequency bytes, accumulator
// Assumes: every link pin is asynchronous and passes two flip-flops
// Notes:   pin reset acts only together with commit
//
// Notes on behaviour
// (R1) strobe rise with select low stores byte
// (R2) data bit 7 is byte msb
// (R3) select bus bit 3 is msb
// (R4) strobes with select high are ignored
// (R5) accumulator and sample advance every clock
// (R6) strobe side crosses safely into clock
// (R7) reset restores default register values
// (R8) reset clears accumulator feedback to zero
// (R9) reset needs commit asserted too
// (R10) commit copies staged bytes to active
// (R11) commit leaves gate and quadrant untouched
// (R12) write all, then commit moves all
// (R13) commit held passes each byte through
// (R14) selects 0-5 center, 6-11 offset, lsb first
// (R15) center msb resets 40h, rest zero
// (R16) offset gate low zeroes offset term
// (R17) writes accepted one clock after reset
// (R18) increment is 48-bit sum, carry dropped
// (R19) commit and reset synchronised before use
`timescale 1ns/10ps
`default_nettype none
`include "ddshp_params.svh"

module ddshp_device #(
  parameter int NREG = `DDSHP_NUM_REGS
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  ddshp_if.dev                    lnk,
  output var ddshp_pkg::ddshp_sample_t sample_q,
  output var ddshp_pkg::ddshp_word_t   phase_q,
  output wire ddshp_pkg::ddshp_word_t  center_word,
  output wire ddshp_pkg::ddshp_word_t  offset_freq_word
);
  import ddshp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int PIN_W      = 19;
  localparam int STB_BIT    = 18;
  localparam int SELN_BIT   = 17;
  localparam int SEL_LSB    = 13;
  localparam int DATA_LSB   = 5;
  localparam int COMMIT_BIT = 4;
  localparam int RESET_BIT  = 3;
  localparam int GATE_BIT   = 2;

  // idle levels: leaving reset shows no strobe edge and no pin reset
  localparam logic [PIN_W-1:0] PIN_IDLE = {
    1'h0,
    1'h1,
    {`DDSHP_SEL_W{1'h0}},
    {`DDSHP_DATA_W{1'h0}},
    1'h1,
    1'h1,
    1'h0,
    2'h0
  };

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic             strobe_s3_q;

  // bit order: strobe, sel_n, sel, data, commit_n, reset_n, gate, quad
  assign pin_raw = {lnk.wr_strobe, lnk.wr_sel_n, lnk.reg_sel, lnk.data,
                    lnk.commit_n, lnk.reset_n, lnk.offset_gate,
                    lnk.phase_quadrant_sel};

  // two-flop synchroniser on every link pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_q <= PIN_IDLE;
      pin_s2_q <= PIN_IDLE;
    end else begin
      pin_s1_q <= pin_raw;                         // [R6] [R19]
      pin_s2_q <= pin_s1_q;
    end
  end

  // one more flop on the settled strobe for its edge detector
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strobe_s3_q <= PIN_IDLE[STB_BIT];
    end else begin
      strobe_s3_q <= pin_s2_q[STB_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded pin levels

  // every level below is read from the second flop only
  wire              strobe_s = pin_s2_q[STB_BIT];
  wire              sel_n_s  = pin_s2_q[SELN_BIT];
  wire ddshp_sel_t  sel_s    = pin_s2_q[SEL_LSB +: `DDSHP_SEL_W];    // [R3]
  wire ddshp_byte_t data_s   = pin_s2_q[DATA_LSB +: `DDSHP_DATA_W];  // [R2]
  wire              commit_s = ~pin_s2_q[COMMIT_BIT];
  wire              reset_s  = ~pin_s2_q[RESET_BIT];
  wire              gate_s   = pin_s2_q[GATE_BIT];
  wire [1:0]        quad_s   = pin_s2_q[1:0];

  ////////////////////////////////////////////////////////////////////////
  // write and reset qualifiers

  wire strobe_rise = strobe_s & ~strobe_s3_q;
  wire write_go    = strobe_rise & ~sel_n_s;      // [R1] [R4]
  wire pin_reset   = reset_s & commit_s;          // [R9]
  wire clear_all   = rst | pin_reset;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic sel_hit(input ddshp_sel_t sel, input int idx);
    sel_hit = (sel == idx[`DDSHP_SEL_W-1:0]);     // [R3]
  endfunction : sel_hit

  function automatic ddshp_byte_t reset_byte(input int idx);
    if (idx == `DDSHP_CF_MSB_IDX)
      reset_byte = `DDSHP_CF_MSB_RESET;           // [R15]
    else
      reset_byte = `DDSHP_BYTE_RESET;
  endfunction : reset_byte

  ////////////////////////////////////////////////////////////////////////
  // staged and active bytes

  ddshp_byte_t stage_q [NREG];
  ddshp_byte_t act_q   [NREG];

  // one staging and one active byte per select
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_byte
      wire wr_hit = write_go & sel_hit(sel_s, g);

      // staging byte: reset wins over a write in the same clock
      always_ff @(posedge core_clk) begin
        if (clear_all) begin
          stage_q[g] <= reset_byte(g);            // [R7] [R15]
        end else if (wr_hit) begin
          stage_q[g] <= data_s;                   // [R1] [R17]
        end
      end

      // active byte: follows staging while commit is held
      always_ff @(posedge core_clk) begin
        if (clear_all) begin
          act_q[g] <= reset_byte(g);              // [R7]
        end else if (commit_s) begin
          act_q[g] <= stage_q[g];                 // [R10] [R12] [R13]
        end
      end

      // center bytes first, then offset bytes, each lsb first
      if (g < `DDSHP_OF_BASE) begin : g_cf
        assign center_word[8*g +: 8] = act_q[g];  // [R14]
      end else begin : g_of
        assign offset_freq_word[8*(g-`DDSHP_OF_BASE) +: 8] = act_q[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // phase accumulator and sample

  localparam int QUAD_PAD = `DDSHP_SAMPLE_W - 2;

  ddshp_word_t   offset_term;
  ddshp_word_t   incr;
  ddshp_word_t   phase_d;
  ddshp_sample_t quad_add;
  ddshp_sample_t sample_d;

  // gate and quadrant bypass the staging entirely
  assign offset_term = gate_s ? offset_freq_word : '0;     // [R16] [R11]
  assign incr        = center_word + offset_term;          // [R18]
  assign quad_add    = {quad_s, {QUAD_PAD{1'h0}}};
  assign phase_d     = phase_q + incr;                     // [R5] [R18]
  assign sample_d    = phase_q[`DDSHP_WORD_W-1 -: `DDSHP_SAMPLE_W] + quad_add;

  // accumulator: feedback cleared by either reset
  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      phase_q <= '0;                              // [R8]
    end else begin
      phase_q <= phase_d;                         // [R5]
    end
  end

  // sample: one clock behind the accumulator
  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      sample_q <= '0;                             // [R8]
    end else begin
      sample_q <= sample_d;                       // [R5]
    end
  end

endmodule : ddshp_device

`default_nettype wire

// ===== logic/ddshp_host.sv
// Purpose: host end: paces byte writes and drives commit, reset, modulation
// Assumes: device samples pins through two flip-flops
// Notes:   each strobe phase held DDSHP_PHASE_CYC clocks
`timescale 1ns/10ps
`default_nettype none
`include "ddshp_params.svh"

module ddshp_host (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  ddshp_if.hst                       lnk,
  input  wire logic                  wr_valid,
  input  wire ddshp_pkg::ddshp_sel_t wr_sel,
  input  wire ddshp_pkg::ddshp_byte_t wr_data,
  output var logic                   wr_ready_q,
  input  wire logic                  commit_req,
  input  wire logic                  reset_req,
  input  wire logic                  gate_req,
  input  wire logic [1:0]            quad_req
);
  import ddshp_pkg::*;

  localparam logic [`DDSHP_CNT_W-1:0] PHASE_LAST =
    `DDSHP_CNT_W'(`DDSHP_PHASE_CYC - 1);

  ddshp_hstate_t            st_q;
  logic [`DDSHP_CNT_W-1:0]  cnt_q;
  logic                     strobe_q;
  logic                     sel_n_q;
  ddshp_sel_t               sel_q;
  ddshp_byte_t              data_q;
  logic                     commit_n_q;
  logic                     reset_n_q;
  logic                     gate_q;
  logic [1:0]               quad_q;

  wire take    = (st_q == DDSHP_H_IDLE) & wr_valid & wr_ready_q;
  wire cnt_end = (cnt_q == '0);

  ////////////////////////////////////////////////////////////////////////
  // write sequencer

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q       <= DDSHP_H_IDLE;
      cnt_q      <= '0;
      strobe_q   <= 1'b0;
      sel_n_q    <= 1'b1;
      sel_q      <= '0;
      data_q     <= '0;
      wr_ready_q <= 1'b0;
    end else begin
      unique case (st_q)
        DDSHP_H_IDLE: begin
          wr_ready_q <= ~take;
          if (take) begin
            sel_n_q <= 1'b0;                      // [R4]
            sel_q   <= wr_sel;
            data_q  <= wr_data;
            cnt_q   <= PHASE_LAST;
            st_q    <= DDSHP_H_SETUP;
          end
        end
        DDSHP_H_SETUP: begin
          cnt_q <= cnt_end ? PHASE_LAST : cnt_q - 1'b1;
          if (cnt_end) begin
            strobe_q <= 1'b1;                     // [R1]
            st_q     <= DDSHP_H_HIGH;
          end
        end
        DDSHP_H_HIGH: begin
          cnt_q <= cnt_end ? PHASE_LAST : cnt_q - 1'b1;
          if (cnt_end) begin
            strobe_q <= 1'b0;
            st_q     <= DDSHP_H_HOLD;
          end
        end
        DDSHP_H_HOLD: begin
          cnt_q <= cnt_end ? '0 : cnt_q - 1'b1;
          if (cnt_end) begin
            sel_n_q    <= 1'b1;                   // [R4]
            wr_ready_q <= 1'b1;
            st_q       <= DDSHP_H_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // level pins

  always_ff @(posedge core_clk) begin
    if (rst) begin
      commit_n_q <= 1'b1;
      reset_n_q  <= 1'b1;
      gate_q     <= 1'b0;
      quad_q     <= 2'h0;
    end else begin
      commit_n_q <= ~(commit_req | reset_req);    // [R9] [R12] [R13]
      reset_n_q  <= ~reset_req;
      gate_q     <= gate_req;
      quad_q     <= quad_req;
    end
  end

  assign lnk.wr_strobe          = strobe_q;
  assign lnk.wr_sel_n           = sel_n_q;
  assign lnk.reg_sel            = sel_q;
  assign lnk.data               = data_q;
  assign lnk.commit_n           = commit_n_q;
  assign lnk.reset_n            = reset_n_q;
  assign lnk.offset_gate        = gate_q;
  assign lnk.phase_quadrant_sel = quad_q;

endmodule : ddshp_host

`default_nettype wire

// ===== tb/ddshp_asserts.sv
// Purpose: checker on the host to oscillator pins
// Assumes: host walk of 3 clocks per strobe phase
// Notes:   takes the interface signals as plain inputs
`timescale 1ns/10ps
`default_nettype none

module ddshp_asserts (
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire logic                   wr_strobe,
  input wire logic                   wr_sel_n,
  input wire ddshp_pkg::ddshp_sel_t  reg_sel,
  input wire ddshp_pkg::ddshp_byte_t data,
  input wire logic                   commit_n,
  input wire logic                   reset_n,
  input wire logic                   offset_gate,
  input wire logic [1:0]             phase_quadrant_sel
);
  import ddshp_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  strobe_sel_a: assert property ($rose(wr_strobe) |-> !wr_sel_n)
    else $error("strobe rose without select");
  strobe_setup_a: assert property ($fell(wr_sel_n) |->
    !wr_strobe [*3] ##1 wr_strobe) else $error("strobe setup wrong");
  strobe_width_a: assert property ($rose(wr_strobe) |->
    wr_strobe [*3] ##1 !wr_strobe) else $error("strobe width wrong");
  sel_hold_a: assert property ($fell(wr_strobe) |->
    !wr_sel_n [*3] ##1 wr_sel_n) else $error("select hold wrong");
  data_stable_a: assert property ((!wr_sel_n && !$past(wr_sel_n)) |->
    $stable(data) && $stable(reg_sel)) else $error("data moved");
  reset_commit_a: assert property (!reset_n |-> !commit_n)
    else $error("reset without commit");
  idle_strobe_a: assert property (wr_sel_n |-> !wr_strobe)
    else $error("strobe high while idle");
  start_idle_a: assert property ($past(rst) |->
    wr_sel_n && commit_n && reset_n) else $error("pins busy after reset");
  quad_c: cover property ($changed(phase_quadrant_sel));
  gate_c: cover property ($rose(offset_gate));
endmodule : ddshp_asserts

`default_nettype wire

// ===== tb/tb_dds_host_write_port.sv
// Purpose: bench joining host and oscillator ends
// Assumes: 250 MHz core clock, inputs driven on the falling edge
// Notes:   expected words are built from the bytes written
`timescale 1ns/10ps
`default_nettype none

module tb_dds_host_write_port;
  import ddshp_pkg::*;
  localparam ddshp_word_t CEN_RST = 48'h4000_0000_0000;
  logic          core_clk, rst, wr_valid, wr_ready_q;
  logic          commit_req, reset_req, gate_req;
  logic [1:0]    quad_req;
  ddshp_sel_t    wr_sel;
  ddshp_byte_t   wr_data;
  ddshp_sample_t sample_q;
  ddshp_word_t   phase_q, center_word, offset_freq_word, cen, ofs;
  int            n_mismatch = 0;
  int            compares = 0;
  ddshp_if lnk_if ();
  ddshp_host ddshp_host_i (.core_clk(core_clk), .rst(rst), .lnk(lnk_if),
    .wr_valid(wr_valid), .wr_sel(wr_sel), .wr_data(wr_data),
    .wr_ready_q(wr_ready_q), .commit_req(commit_req),
    .reset_req(reset_req), .gate_req(gate_req), .quad_req(quad_req));
  ddshp_device #(.NREG(12)) ddshp_device_i (.core_clk(core_clk),
    .rst(rst), .lnk(lnk_if), .sample_q(sample_q), .phase_q(phase_q),
    .center_word(center_word), .offset_freq_word(offset_freq_word));
  ddshp_asserts ddshp_asserts_i (.core_clk(core_clk), .rst(rst),
    .wr_strobe(lnk_if.wr_strobe), .wr_sel_n(lnk_if.wr_sel_n),
    .reg_sel(lnk_if.reg_sel), .data(lnk_if.data),
    .commit_n(lnk_if.commit_n), .reset_n(lnk_if.reset_n),
    .offset_gate(lnk_if.offset_gate),
    .phase_quadrant_sel(lnk_if.phase_quadrant_sel));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input ddshp_word_t seen, input ddshp_word_t exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input ddshp_sel_t s, input ddshp_byte_t d);
    while (wr_ready_q !== 1'b1) @(negedge core_clk);
    wr_valid = 1'b1;
    wr_sel = s;
    wr_data = d;
    @(negedge core_clk);
    wr_valid = 1'b0;
    chk(48'(wr_ready_q), '0); // busy while select held
    @(negedge core_clk);
    while (wr_ready_q !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
  endtask : wr
  task automatic commit();
    commit_req = 1'b1;
    repeat (6) @(negedge core_clk);
    commit_req = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : commit
  task automatic step(input ddshp_word_t inc);
    ddshp_word_t p;
    @(negedge core_clk);
    p = phase_q;
    @(negedge core_clk);
    chk(phase_q - p, inc);
  endtask : step
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    chk(center_word, CEN_RST); // center msb
    chk(offset_freq_word, '0); // offset zero
    step(CEN_RST); // advance each clock
  endtask : t_defaults
  task automatic t_batch();
    cen = '0;
    for (int i = 0; i < 6; i++) begin
      cen[8*i+:8] = 8'h81 + 8'(i);
      wr(4'(i), 8'h81 + 8'(i));
    end
    chk(center_word, CEN_RST); // staged only
    commit();
    chk(center_word, cen); // whole word at once
    chk(offset_freq_word, '0); // offset still zero
  endtask : t_batch
  task automatic t_pass();
    commit_req = 1'b1;
    repeat (4) @(negedge core_clk);
    ofs = '0;
    for (int i = 0; i < 6; i++) begin
      ofs[8*i+:8] = 8'hf0 + 8'(i);
      wr(4'(6 + i), 8'hf0 + 8'(i));
      chk(offset_freq_word, ofs); // byte passes
    end
    wr(4'hc, 8'h3c);
    chk(center_word, cen); // unused select
    chk(offset_freq_word, ofs); // unused select
    commit_req = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : t_pass
  task automatic t_gate();
    step(cen); // gate low
    gate_req = 1'b1;
    repeat (6) @(negedge core_clk);
    step(cen + ofs); // carry dropped
    gate_req = 1'b0;
    repeat (6) @(negedge core_clk);
    step(cen); // offset kept but gated
    chk(offset_freq_word, ofs); // stored offset untouched
  endtask : t_gate
  task automatic t_quad();
    ddshp_word_t p;
    quad_req = 2'b10;
    repeat (6) @(negedge core_clk);
    p = phase_q;
    @(negedge core_clk);
    chk(48'(sample_q), 48'(16'(p[47:32] + 16'h8000))); // quadrant
    quad_req = 2'b00;
  endtask : t_quad
  task automatic t_pin_reset();
    reset_req = 1'b1;
    repeat (6) @(negedge core_clk);
    chk(phase_q, '0); // phase zeroed
    chk(center_word, CEN_RST); // defaults
    chk(offset_freq_word, '0); // defaults
    reset_req = 1'b0;
    repeat (4) @(negedge core_clk);
    wr(4'h0, 8'h5a);
    commit();
    chk(center_word, CEN_RST | 48'h5a); // write after reset
  endtask : t_pin_reset
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3000) @(posedge core_clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    wr_valid = 1'b0;
    wr_sel = '0;
    wr_data = '0;
    commit_req = 1'b0;
    reset_req = 1'b0;
    gate_req = 1'b0;
    quad_req = 2'b00;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    t_defaults();
    t_batch();
    t_pass();
    t_gate();
    t_quad();
    t_pin_reset();
    end_of_test();
  end
endmodule : tb_dds_host_write_port

`default_nettype wire
